// ==== verilog/sec_cmd_pkg.sv ====
// Constants, types and register map of the security command interpreter.
// Functional notes
// RULE_01 - Accepted freeze command enters frozen state
// RULE_02 - Frozen rejects every lock-altering command
// RULE_03 - Only reset leaves frozen; no command
// RULE_04 - Freeze while frozen completes, stays frozen
// RULE_05 - Freeze aborts if unsupported or locked
// RULE_06 - Success: BSY0 DRDY1 DF0 DRQ0 ERR0
// RULE_07 - Abort: BSY0 DRQ0 DRDY1, ERR mirrors errors
// RULE_08 - Abort allowed for any other inability
// RULE_09 - Host issues commands only with DRDY
// RULE_10 - Set-password moves one sector host to device
// RULE_11 - Set-password aborts: unsupported, frozen or locked
// RULE_12 - Decode identifier, level, 16 password words
// RULE_13 - Drive-select bit kept, reflected on completion
// RULE_14 - User password stored, lock enabled, level set
// RULE_15 - Master password stored, lock and level kept
// RULE_16 - Ignore reserved bits; need full sector first
package sec_cmd_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses on the APB.
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CMD     = 8'h00; // Command code, write only.
    localparam logic [7:0] OFS_DEVHEAD = 8'h04; // drive_select_head.
    localparam logic [7:0] OFS_STATUS  = 8'h08; // status_flags.
    localparam logic [7:0] OFS_ERROR   = 8'h0C; // error_flags.
    localparam logic [7:0] OFS_DATA    = 8'h10; // PIO data-out word port.
    localparam logic [7:0] OFS_SECST   = 8'h14; // Security state, read only.
    localparam logic [7:0] OFS_IRQST   = 8'h18; // Sticky events, read clears.
    localparam logic [7:0] OFS_IRQMSK  = 8'h1C; // Interrupt mask.
    localparam logic [7:0] OFS_CONFIG  = 8'h20; // Support and lock control.

    // ------------------------------------------------------------------
    // Command codes and field positions.
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_FREEZE = 8'hF5;
    localparam logic [7:0] CMD_SETPW  = 8'hF1;
    localparam int BIT_BSY  = 7;
    localparam int BIT_DRDY = 6;
    localparam int BIT_DF   = 5;
    localparam int BIT_DRQ  = 3;
    localparam int BIT_ERR  = 0;
    localparam int BIT_ABRT = 2;
    localparam int BIT_DEV  = 4;
    localparam int BIT_IDENT = 0;   // Control word: 1 selects master.
    localparam int BIT_LEVEL = 8;   // Control word: 1 selects maximum.
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_ABORT = 1;
    localparam int IRQ_DRQ   = 2;
    localparam int CFG_SUPP  = 0;
    localparam int CFG_LOCK  = 1;

    // ------------------------------------------------------------------
    // Status values and reset values.
    // ------------------------------------------------------------------
    localparam logic [7:0] STS_RESET = 8'h40; // Ready, idle.
    localparam logic [7:0] STS_BUSY  = 8'h80;
    localparam logic [7:0] STS_OK    = 8'h40;
    localparam logic [7:0] STS_DRQ   = 8'h48;
    localparam logic [7:0] STS_ABORT = 8'h41;
    localparam logic [7:0] ERR_ABORT = 8'h04;
    localparam logic [7:0] ERR_NONE  = 8'h00;
    localparam logic [1:0] CFG_RESET = 2'h1;  // Supported, unlocked.

    // Command sequencer states, Gray coded along the usual path.
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_EXEC   = 2'b01,
        ST_XFER   = 2'b11,
        ST_COMMIT = 2'b10
    } seq_state_t;

endpackage : sec_cmd_pkg

// ==== verilog/sec_pw_if.sv ====
// Link between the command sequencer and the password store.
`timescale 1ns/1ns
interface sec_pw_if;
    logic        start;      // Pulse: a new sector begins.
    logic        word_valid; // Pulse: one data word is offered.
    logic [15:0] word_data;  // Data word with word_valid.
    logic        commit;     // Pulse: store the decoded password.
    logic        done;       // Pulse: the full sector has arrived.
    logic        ident;      // 1 selects the master password.
    logic        level_max;  // 1 selects maximum level.

    modport ctl   (output start, word_valid, word_data, commit,
                   input  done, ident, level_max);
    modport store (input  start, word_valid, word_data, commit,
                   output done, ident, level_max);
endinterface : sec_pw_if

// ==== verilog/sec_pw_store.sv ====
// Sector capture and password storage for the set-password command.
`timescale 1ns/1ns
module sec_pw_store #(
    parameter int SECTOR_WORDS = 256,
    parameter int PW_WORDS     = 16
) (
    input  wire logic MCLK,
    input  wire logic RESET,
    sec_pw_if.store   pw
);

    // ------------------------------------------------------------------
    // State of the store.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [8:0]                   cnt;    // Words received.
        logic [15:0]                  ctrl;   // Word 0 of the sector.
        logic [PW_WORDS-1:0][15:0]    buf_w;  // Incoming password words.
        logic [PW_WORDS-1:0][15:0]    user;   // Stored user password.
        logic [PW_WORDS-1:0][15:0]    master; // Stored master password.
        logic                         done;   // Sector complete pulse.
    } store_t;

    store_t r_q;  // Registered state.
    store_t r_d;  // Next state.

    // Next-state logic: counts words and keeps only the useful ones.
    always_comb
    begin
        r_d      = r_q;
        r_d.done = 1'b0;
        if (pw.start)
        begin
            r_d.cnt = 9'h000;
        end
        else if (pw.word_valid && r_q.cnt < 9'(SECTOR_WORDS))
        begin
            // Reserved words past the password are counted, not kept.
            if (r_q.cnt == 9'h000)
                r_d.ctrl = pw.word_data;                       // RULE_12
            else if (r_q.cnt <= 9'(PW_WORDS))
                r_d.buf_w[r_q.cnt - 9'h001] = pw.word_data;    // RULE_12
            r_d.cnt  = r_q.cnt + 9'h001;
            // Nothing is acted on until the last word lands.
            r_d.done = (r_q.cnt == 9'(SECTOR_WORDS - 1));      // RULE_16
        end
        if (pw.commit)
        begin
            // Only the identifier bit chooses the target slot.
            if (r_q.ctrl[sec_cmd_pkg::BIT_IDENT])
                r_d.master = r_q.buf_w;                        // RULE_15
            else
                r_d.user = r_q.buf_w;                          // RULE_14
        end
    end

    // State register.
    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    // Reserved control bits never reach the sequencer.
    assign pw.done      = r_q.done;
    assign pw.ident     = r_q.ctrl[sec_cmd_pkg::BIT_IDENT];
    assign pw.level_max = r_q.ctrl[sec_cmd_pkg::BIT_LEVEL];

endmodule : sec_pw_store

// ==== verilog/sec_cmd.sv ====
// Security freeze and set-password command interpreter with APB registers.
`timescale 1ns/1ns
module sec_cmd #(
    parameter logic DEV_NUMBER = 1'b0  // Device number this unit answers to.
) (
    input  wire logic        MCLK,
    input  wire logic        RESET,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             IRQ,
    output logic             FROZEN,
    output logic             LOCKED,
    output logic             LOCK_ENABLED,
    output logic             LEVEL_MAX
);

    // ------------------------------------------------------------------
    // State of the interpreter.
    // ------------------------------------------------------------------
    typedef struct packed {
        sec_cmd_pkg::seq_state_t st;       // Sequencer state.
        logic [7:0]              cmd;      // Command being executed.
        logic [7:0]              status;   // status_flags.
        logic [7:0]              error;    // error_flags.
        logic [7:0]              devhead;  // drive_select_head.
        logic                    frozen;   // Frozen mode.
        logic                    locked;   // Locked mode.
        logic                    lock_en;  // Lock enabled by user password; cleared by RESET.
        logic                    lvl_max;  // Maximum security level.
        logic                    supp;     // Feature set supported.
        logic [2:0]              irq_st;   // Sticky events.
        logic [2:0]              irq_msk;  // Event mask.
        logic [31:0]             rdata;    // Read data for the access phase.
    } core_t;

    core_t r_q;  // Registered state.
    core_t r_d;  // Next state.

    sec_pw_if pw ();  // Link to the password store.

    logic       setup;   // APB setup cycle.
    logic       access;  // APB access cycle, always answered.
    logic       wr;      // Write takes effect this edge.
    logic       rd;      // Read completes this edge.
    logic       mapped;  // Address hits a register.
    logic [2:0] ev;      // Events raised this cycle.

    // ------------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------------

    // Returns the register value seen at a byte address.
    function automatic logic [31:0] reg_read(input core_t c, input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            sec_cmd_pkg::OFS_DEVHEAD: v[7:0] = c.devhead;
            sec_cmd_pkg::OFS_STATUS:  v[7:0] = c.status;
            sec_cmd_pkg::OFS_ERROR:   v[7:0] = c.error;
            sec_cmd_pkg::OFS_SECST:   v[3:0] = {c.lvl_max, c.lock_en, c.locked, c.frozen};
            sec_cmd_pkg::OFS_IRQST:   v[2:0] = c.irq_st;
            sec_cmd_pkg::OFS_IRQMSK:  v[2:0] = c.irq_msk;
            sec_cmd_pkg::OFS_CONFIG:  v[1:0] = {c.locked, c.supp};
            default:                  v      = 32'h0000_0000;
        endcase
        return v;
    endfunction : reg_read

    assign setup  = PSEL && !PENABLE;
    assign access = PSEL && PENABLE;
    assign wr     = access && PWRITE;
    assign rd     = access && !PWRITE;
    assign mapped = (PADDR <= sec_cmd_pkg::OFS_CONFIG) && (PADDR[1:0] == 2'b00);

    // Zero-wait slave: every access completes on its first access cycle.
    assign PREADY  = 1'b1;
    assign PSLVERR = access && !mapped;
    assign PRDATA  = r_q.rdata;

    // ------------------------------------------------------------------
    // Sequencer, registers and interrupt logic.
    // ------------------------------------------------------------------

    // One process computes every next value so that no flag has two writers.
    always_comb
    begin
        r_d           = r_q;
        ev            = 3'h0;
        pw.start      = 1'b0;
        pw.word_valid = 1'b0;
        pw.word_data  = PWDATA[15:0];
        pw.commit     = 1'b0;
        if (setup)
            r_d.rdata = reg_read(r_q, PADDR);
        if (wr && PADDR == sec_cmd_pkg::OFS_DEVHEAD)
            r_d.devhead = PWDATA[7:0];                         // RULE_13
        if (wr && PADDR == sec_cmd_pkg::OFS_IRQMSK)
            r_d.irq_msk = PWDATA[2:0];
        if (wr && PADDR == sec_cmd_pkg::OFS_CONFIG)
        begin
            // Locked mode is set by firmware after its own power-on check.
            r_d.supp   = PWDATA[sec_cmd_pkg::CFG_SUPP];
            r_d.locked = PWDATA[sec_cmd_pkg::CFG_LOCK];
        end
        unique case (r_q.st)
            sec_cmd_pkg::ST_IDLE:
            begin
                // A command while busy is dropped; host must wait for DRDY.
                if (wr && PADDR == sec_cmd_pkg::OFS_CMD
                    && r_q.devhead[sec_cmd_pkg::BIT_DEV] == DEV_NUMBER)  // RULE_09
                begin
                    r_d.cmd    = PWDATA[7:0];
                    r_d.status = sec_cmd_pkg::STS_BUSY;
                    r_d.st     = sec_cmd_pkg::ST_EXEC;
                end
            end
            sec_cmd_pkg::ST_EXEC:
            begin
                r_d.st = sec_cmd_pkg::ST_IDLE;
                if (r_q.cmd == sec_cmd_pkg::CMD_FREEZE && r_q.supp && !r_q.locked)
                begin
                    r_d.frozen = 1'b1;                                  // RULE_01 RULE_04
                    r_d.status = sec_cmd_pkg::STS_OK;                   // RULE_06
                    r_d.error  = sec_cmd_pkg::ERR_NONE;
                    ev[sec_cmd_pkg::IRQ_DONE] = 1'b1;
                end
                else if (r_q.cmd == sec_cmd_pkg::CMD_SETPW && r_q.supp
                         && !r_q.frozen && !r_q.locked)                 // RULE_11
                begin
                    r_d.status = sec_cmd_pkg::STS_DRQ;                  // RULE_10
                    r_d.error  = sec_cmd_pkg::ERR_NONE;
                    r_d.st     = sec_cmd_pkg::ST_XFER;
                    pw.start   = 1'b1;
                    ev[sec_cmd_pkg::IRQ_DRQ] = 1'b1;
                end
                else
                begin
                    // Unsupported, locked, frozen set-password or unknown: all abort.
                    r_d.status = sec_cmd_pkg::STS_ABORT;                // RULE_02 RULE_05 RULE_07 RULE_08
                    r_d.error  = sec_cmd_pkg::ERR_ABORT;
                    ev[sec_cmd_pkg::IRQ_ABORT] = 1'b1;
                end
            end
            sec_cmd_pkg::ST_XFER:
            begin
                pw.word_valid = wr && PADDR == sec_cmd_pkg::OFS_DATA;   // RULE_10
                if (pw.done)
                begin
                    r_d.status = sec_cmd_pkg::STS_BUSY;
                    r_d.st     = sec_cmd_pkg::ST_COMMIT;
                end
            end
            sec_cmd_pkg::ST_COMMIT:
            begin
                pw.commit = 1'b1;
                if (!pw.ident)
                begin
                    r_d.lock_en = 1'b1;                                 // RULE_14
                    r_d.lvl_max = pw.level_max;                         // RULE_14
                end
                r_d.status = sec_cmd_pkg::STS_OK;                       // RULE_06
                r_d.st     = sec_cmd_pkg::ST_IDLE;
                ev[sec_cmd_pkg::IRQ_DONE] = 1'b1;
            end
        endcase
        // A read clears the sticky bits, but a new event wins.
        if (rd && PADDR == sec_cmd_pkg::OFS_IRQST)
            r_d.irq_st = ev;
        else
            r_d.irq_st = r_q.irq_st | ev;
    end

    // State register; frozen is cleared by RESET alone.
    always_ff @(posedge MCLK or posedge RESET)
    begin
        if (RESET)
        begin
            r_q         <= '0;                                          // RULE_03
            r_q.st      <= sec_cmd_pkg::ST_IDLE;
            r_q.status  <= sec_cmd_pkg::STS_RESET;
            r_q.supp    <= sec_cmd_pkg::CFG_RESET[sec_cmd_pkg::CFG_SUPP];
        end
        else
        begin
            r_q <= r_d;
        end
    end

    sec_pw_store u_store (
        .MCLK  (MCLK),
        .RESET (RESET),
        .pw    (pw)
    );

    assign IRQ          = |(r_q.irq_st & r_q.irq_msk);
    assign FROZEN       = r_q.frozen;
    assign LOCKED       = r_q.locked;
    assign LOCK_ENABLED = r_q.lock_en;
    assign LEVEL_MAX    = r_q.lvl_max;

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    property p_freeze_ok;
        r_q.st == sec_cmd_pkg::ST_EXEC && r_q.cmd == sec_cmd_pkg::CMD_FREEZE
        && r_q.supp && !r_q.locked |=> FROZEN && r_q.status == sec_cmd_pkg::STS_OK;
    endproperty
    a_freeze_ok: assert property (p_freeze_ok) else $error("freeze did not freeze"); // RULE_01

    property p_frozen_sticks;
        FROZEN |=> FROZEN;
    endproperty
    a_frozen_sticks: assert property (p_frozen_sticks) else $error("frozen left"); // RULE_03

    property p_refreeze;
        FROZEN && r_q.st == sec_cmd_pkg::ST_EXEC && r_q.cmd == sec_cmd_pkg::CMD_FREEZE
        && r_q.supp && !r_q.locked |=> r_q.error == sec_cmd_pkg::ERR_NONE && FROZEN;
    endproperty
    a_refreeze: assert property (p_refreeze) else $error("refreeze failed"); // RULE_04

    property p_freeze_locked;
        r_q.st == sec_cmd_pkg::ST_EXEC && r_q.cmd == sec_cmd_pkg::CMD_FREEZE && r_q.locked
        |=> r_q.error[sec_cmd_pkg::BIT_ABRT] && $stable(FROZEN);
    endproperty
    a_freeze_locked: assert property (p_freeze_locked) else $error("locked freeze ran"); // RULE_05

    property p_frozen_rejects;
        r_q.st == sec_cmd_pkg::ST_EXEC && FROZEN && r_q.cmd != sec_cmd_pkg::CMD_FREEZE
        |=> r_q.status == sec_cmd_pkg::STS_ABORT && r_q.st == sec_cmd_pkg::ST_IDLE;
    endproperty
    a_frozen_rejects: assert property (p_frozen_rejects) else $error("frozen ran cmd"); // RULE_02 RULE_11

    property p_err_status;
        r_q.status[sec_cmd_pkg::BIT_ERR] |-> r_q.error != 8'h00
        && !r_q.status[sec_cmd_pkg::BIT_BSY] && !r_q.status[sec_cmd_pkg::BIT_DRQ]
        && r_q.status[sec_cmd_pkg::BIT_DRDY];
    endproperty
    a_err_status: assert property (p_err_status) else $error("abort status bad"); // RULE_07

    property p_setpw_drq;
        r_q.st == sec_cmd_pkg::ST_EXEC && r_q.cmd == sec_cmd_pkg::CMD_SETPW && r_q.supp
        && !FROZEN && !r_q.locked |=> r_q.status == sec_cmd_pkg::STS_DRQ
        && r_q.st == sec_cmd_pkg::ST_XFER;
    endproperty
    a_setpw_drq: assert property (p_setpw_drq) else $error("no data request"); // RULE_10

    property p_commit_ok;
        r_q.st == sec_cmd_pkg::ST_COMMIT |=> r_q.status == sec_cmd_pkg::STS_OK
        && r_q.st == sec_cmd_pkg::ST_IDLE && $past(r_q.status) == sec_cmd_pkg::STS_BUSY;
    endproperty
    a_commit_ok: assert property (p_commit_ok) else $error("bad completion"); // RULE_06

    property p_user_pw;
        r_q.st == sec_cmd_pkg::ST_COMMIT && !pw.ident
        |=> LOCK_ENABLED && LEVEL_MAX == $past(pw.level_max);
    endproperty
    a_user_pw: assert property (p_user_pw) else $error("user pw lock wrong"); // RULE_14

    property p_master_pw;
        r_q.st == sec_cmd_pkg::ST_COMMIT && pw.ident |=> $stable(LOCK_ENABLED)
        && $stable(LEVEL_MAX);
    endproperty
    a_master_pw: assert property (p_master_pw) else $error("master changed lock"); // RULE_15

    c_freeze:  cover property (r_q.st == sec_cmd_pkg::ST_EXEC ##1 $rose(FROZEN));
    c_setpw:   cover property (r_q.st == sec_cmd_pkg::ST_COMMIT);
    c_abort:   cover property ($rose(r_q.status[sec_cmd_pkg::BIT_ERR]));
    c_irq:     cover property ($rose(IRQ));

endmodule : sec_cmd

// ==== sim/sec_host_model.sv ====
// Host adapter model: an APB master that issues task-file register transfers.
`timescale 1ns/1ns
module sec_host_model (
    input  wire logic        MCLK,
    output logic             PSEL,
    output logic             PENABLE,
    output logic             PWRITE,
    output logic      [7:0]  PADDR,
    output logic      [31:0] PWDATA,
    input  wire logic [31:0] PRDATA,
    input  wire logic        PREADY,
    input  wire logic        PSLVERR
);
    // The bus starts idle so the device sees no request during reset.
    initial
    begin
        PSEL    = 1'b0;
        PENABLE = 1'b0;
        PWRITE  = 1'b0;
        PADDR   = 8'h00;
        PWDATA  = 32'h0;
    end

    // One transfer: setup, access held until ready, then release.
    // Released address and data are inverted so stale values never look valid.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge MCLK);
        PSEL    <= 1'b1;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do
            @(posedge MCLK);
        while (PREADY !== 1'b1);
        r = PRDATA;
        e = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        PADDR   <= ~a;
        PWDATA  <= ~d;
    endtask : xfer
endmodule : sec_host_model

// ==== sim/security_freeze_and_password_set_bench.sv ====
// Self-checking bench of the security freeze and set-password interpreter.
`timescale 1ns/1ns
module security_freeze_and_password_set_bench;
    logic        MCLK = 1'b0;  // 250 MHz clock.
    logic        RESET = 1'b1; // Held for 12 cycles at start.
    logic        psel, penable, pwrite, pready, pslverr, irq;
    logic        frozen, locked, lock_en, lvl_max, lv;
    logic [7:0]  paddr, dh;
    logic [31:0] pwdata, prdata, rd;
    logic        er;
    int          n_mismatch = 0;
    int          compares = 0;
    int          cycles = 0;

    always #2 MCLK = ~MCLK;

    sec_cmd i_sec_cmd (.MCLK(MCLK), .RESET(RESET), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .FROZEN(frozen),
        .LOCKED(locked), .LOCK_ENABLED(lock_en), .LEVEL_MAX(lvl_max));

    sec_host_model i_sec_host_model (.MCLK(MCLK), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr));

    // ------------------------------------------------------------------
    // Helper tasks.
    // ------------------------------------------------------------------
    task automatic final_report();
        if (n_mismatch == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_sec_host_model.xfer(1'b1, a, d, rd, er);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        i_sec_host_model.xfer(1'b0, a, 32'h0, rd, er);
        check(rd, exp);
    endtask : rd_chk

    // Polls until busy clears, so no command is issued before ready.
    task automatic poll(input logic [7:0] st);
        int k;
        k = 0;
        do
        begin
            i_sec_host_model.xfer(1'b0, sec_cmd_pkg::OFS_STATUS, 32'h0, rd, er);
            k++;
        end
        while (rd[7] !== 1'b0 && k < 50);
        check(rd, {24'h0, st});
        rd_chk(sec_cmd_pkg::OFS_ERROR, (st == sec_cmd_pkg::STS_ABORT) ? 32'h4 : 32'h0);
    endtask : poll

    task automatic cmd(input logic [7:0] c, input logic [7:0] st);
        wr(sec_cmd_pkg::OFS_CMD, {24'h0, c});
        poll(st);
    endtask : cmd

    // Sends a full sector; reserved bits and words carry random junk.
    task automatic setpw(input logic m, input logic l);
        logic [31:0] w;
        cmd(sec_cmd_pkg::CMD_SETPW, sec_cmd_pkg::STS_DRQ);
        for (int k = 0; k < 256; k++)
        begin
            w = $urandom;
            if (k == 0)
                w = {w[31:9], l, w[7:1], m};
            if (k == 255)
                rd_chk(sec_cmd_pkg::OFS_STATUS, 32'h48);
            wr(sec_cmd_pkg::OFS_DATA, w);
        end
        poll(sec_cmd_pkg::STS_OK);
    endtask : setpw

    // A hang counts as a mismatch and ends the run.
    always @(posedge MCLK)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(90839));
        repeat (12) @(posedge MCLK);
        RESET <= 1'b0;
        rd_chk(sec_cmd_pkg::OFS_STATUS, 32'h40);
        rd_chk(sec_cmd_pkg::OFS_SECST, 32'h0);
        rd_chk(sec_cmd_pkg::OFS_CONFIG, 32'h1);
        i_sec_host_model.xfer(1'b0, 8'h24, 32'h0, rd, er);
        check({31'h0, er}, 32'h1);
        wr(sec_cmd_pkg::OFS_IRQMSK, 32'h7);
        // A command aimed at the other device must be ignored.
        dh = 8'($urandom) & 8'hEF;
        wr(sec_cmd_pkg::OFS_DEVHEAD, {24'h0, dh | 8'h10});
        cmd(sec_cmd_pkg::CMD_FREEZE, sec_cmd_pkg::STS_OK);
        check({31'h0, frozen}, 32'h0);
        wr(sec_cmd_pkg::OFS_DEVHEAD, {24'h0, dh});
        lv = 1'($urandom_range(1));
        setpw(1'b0, lv);
        check({30'h0, lock_en, lvl_max}, {30'h0, 1'b1, lv});
        rd_chk(sec_cmd_pkg::OFS_DEVHEAD, {24'h0, dh});
        check({31'h0, irq}, 32'h1);
        rd_chk(sec_cmd_pkg::OFS_IRQST, 32'h5);
        // The read-clear lands at the access edge; look once it has settled.
        @(negedge MCLK);
        check({31'h0, irq}, 32'h0);
        setpw(1'b1, ~lv);
        check({30'h0, lock_en, lvl_max}, {30'h0, 1'b1, lv});
        // Codes outside this block always abort.
        for (int i = 0; i < 8; i++)
            cmd((i < 4) ? 8'hF2 + 8'(i) + 8'(i / 3) : 8'($urandom_range(8'hEF)), 8'h41);
        // Unsupported, then locked: both commands abort.
        for (int i = 0; i < 2; i++)
        begin
            wr(sec_cmd_pkg::OFS_CONFIG, (i == 0) ? 32'h0 : 32'h3);
            cmd(sec_cmd_pkg::CMD_FREEZE, sec_cmd_pkg::STS_ABORT);
            cmd(sec_cmd_pkg::CMD_SETPW, sec_cmd_pkg::STS_ABORT);
            check({30'h0, locked, frozen}, {30'h0, i[0], 1'b0});
        end
        wr(sec_cmd_pkg::OFS_CONFIG, 32'h1);
        wr(sec_cmd_pkg::OFS_IRQMSK, 32'h0);
        rd_chk(sec_cmd_pkg::OFS_IRQST, 32'h7);
        // Freeze, freeze again, then lock-altering and other commands.
        cmd(sec_cmd_pkg::CMD_FREEZE, sec_cmd_pkg::STS_OK);
        check({31'h0, frozen}, 32'h1);
        check({31'h0, irq}, 32'h0);
        rd_chk(sec_cmd_pkg::OFS_IRQST, 32'h1);
        cmd(sec_cmd_pkg::CMD_FREEZE, sec_cmd_pkg::STS_OK);
        cmd(sec_cmd_pkg::CMD_SETPW, sec_cmd_pkg::STS_ABORT);
        cmd(8'hF6, sec_cmd_pkg::STS_ABORT);
        rd_chk(sec_cmd_pkg::OFS_SECST, {28'h0, lv, 3'b101});
        // Only a hardware reset leaves the frozen state.
        RESET <= 1'b1;
        repeat (3) @(posedge MCLK);
        RESET <= 1'b0;
        @(posedge MCLK);
        check({31'h0, frozen}, 32'h0);
        final_report();
    end
endmodule : security_freeze_and_password_set_bench
